// file: dtec_pkg.sv
// constants for the dynamic fan-start temperature control register bank
package dtec_pkg;
    // data widths
    localparam int DTEC_DW = 8;
    localparam int DTEC_BUS_DW = 32;
    localparam int DTEC_PAD_W = DTEC_BUS_DW - DTEC_DW;
    localparam int DTEC_ADDR_W = 10;
    localparam int DTEC_IDX_LSB = 2;
    // register indices; byte address is four times the index
    localparam logic [7:0] DTEC_IDX_ENABLE = 8'h36;
    localparam logic [7:0] DTEC_IDX_CYCLE = 8'h37;
    localparam logic [7:0] DTEC_IDX_OPPT_R2 = 8'h38;
    localparam logic [7:0] DTEC_IDX_FST_LOCAL = 8'h39;
    localparam logic [7:0] DTEC_IDX_FST_R1 = 8'h3a;
    localparam logic [7:0] DTEC_IDX_FST_R2 = 8'h3b;
    localparam logic [7:0] DTEC_IDX_LOCK = 8'h3c;
    localparam logic [7:0] DTEC_IDX_R2_TEMP = 8'h3d;
    // field positions in the enable control register
    localparam int DTEC_BIT_R2_CAPTURE = 4;
    localparam int DTEC_BIT_R1_DYN = 5;
    localparam int DTEC_BIT_LOCAL_DYN = 6;
    localparam int DTEC_BIT_R2_DYN = 7;
    // field position in the lock register
    localparam int DTEC_BIT_LOCK = 0;
    // reset values
    localparam logic [7:0] DTEC_RST_ENABLE = 8'h00;
    localparam logic [7:0] DTEC_RST_CYCLE = 8'h00;
    localparam logic [7:0] DTEC_RST_OPPT = 8'h00;
    localparam logic [7:0] DTEC_RST_FST = 8'h00;
    localparam logic [7:0] DTEC_RST_TEMP = 8'h00;
    localparam logic [7:0] DTEC_ONE = 8'h01;
    // bus handshake states, gray coded
    typedef enum logic [1:0] {
        DTEC_BUS_IDLE = 2'b00,
        DTEC_BUS_ACK = 2'b01
    } dtec_bus_t;
endpackage : dtec_pkg

// file: dtec_regs.sv
// dynamic fan-start temperature control bank with avalon-mm register slave
//
// Summary of operation
// RQ1: capture enabled and overtemp asserted: copy remote 2 temperature to operating point.
// RQ2: capture disabled: overtemp ignored, operating point keeps software value.
// RQ3: remote 1 dynamic enable turns remote 1 fan-start adjustment on or off.
// RQ4: local dynamic enable turns local fan-start adjustment on or off.
// RQ5: remote 2 dynamic enable turns remote 2 fan-start adjustment on or off.
// RQ6: adjustment uses zone temperature, operating point, high and low limits.
// RQ7: disabled zone keeps programmed fan-start temperature unchanged.
// RQ8: once lock bit is set, writes to control registers are rejected.
// RQ9: cycle configuration register resets to zero.
// RQ10: one capture per new overtemp assertion, using last completed measurement.
`timescale 1ns/10ps

// one zone's fan-start temperature, stepped once per adjust tick
module dtec_zone (
    input wire logic clk, // 40 mhz clock
    input wire logic reset, // async, active high
    input wire logic dyn_en, // zone dynamic enable
    input wire logic tick, // adjust tick pulse
    input wire logic [dtec_pkg::DTEC_DW-1:0] temp, // zone temperature
    input wire logic [dtec_pkg::DTEC_DW-1:0] op_point, // operating point
    input wire logic [dtec_pkg::DTEC_DW-1:0] lim_high, // high limit
    input wire logic [dtec_pkg::DTEC_DW-1:0] lim_low, // low limit
    input wire logic sw_wr, // software write strobe
    input wire logic [dtec_pkg::DTEC_DW-1:0] sw_data, // software value
    output logic [dtec_pkg::DTEC_DW-1:0] fan_start // fan-start temp
);
    import dtec_pkg::*;

    logic [DTEC_DW-1:0] fan_start_r;
    logic [DTEC_DW-1:0] fan_start_nxt;
    wire step_w = dyn_en & tick;
    // hot zone lowers the start point, cool zone raises it back
    wire lower_w = (temp > op_point) && (fan_start_r > lim_low); // RQ6
    wire raise_w = (temp < lim_low) && (fan_start_r < lim_high); // RQ6

    // software write wins over a step so a programmed value is never lost
    assign fan_start_nxt = sw_wr ? sw_data :
        (step_w && lower_w) ? fan_start_r - DTEC_ONE :
        (step_w && raise_w) ? fan_start_r + DTEC_ONE :
        fan_start_r; // RQ7

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fan_start_r <= DTEC_RST_FST;
        end else begin
            fan_start_r <= fan_start_nxt;
        end
    end

    assign fan_start = fan_start_r;

    // lowering step of exactly one
    zone_lower_a: assert property (@(posedge clk) disable iff (reset) // RQ6
        (step_w && lower_w && !sw_wr) |=> fan_start_r == $past(fan_start_r) - DTEC_ONE)
        else $error("fan-start did not step down by one");
    // disabled zone holds its value
    zone_hold_a: assert property (@(posedge clk) disable iff (reset) // RQ7
        (!dyn_en && !sw_wr) |=> $stable(fan_start_r))
        else $error("fan-start changed while zone disabled");
endmodule : dtec_zone

// register bank top
module dtec_regs (
    input wire logic clk, // 40 mhz clock
    input wire logic reset, // async, active high
    input wire logic [dtec_pkg::DTEC_ADDR_W-1:0] address, // byte address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [dtec_pkg::DTEC_BUS_DW-1:0] writedata, // write data
    output logic [dtec_pkg::DTEC_BUS_DW-1:0] readdata, // read data
    output logic waitrequest, // avalon stall
    input wire logic overtemp_pin_n, // overtemp pin level, low asserted
    input wire logic remote2_temp_valid, // remote 2 measurement done
    input wire logic [dtec_pkg::DTEC_DW-1:0] remote2_temp, // remote 2 temp
    input wire logic [dtec_pkg::DTEC_DW-1:0] local_temp, // local temp
    input wire logic [dtec_pkg::DTEC_DW-1:0] remote1_temp, // remote 1 temp
    input wire logic [dtec_pkg::DTEC_DW-1:0] local_op_point, // local op pt
    input wire logic [dtec_pkg::DTEC_DW-1:0] remote1_op_point, // r1 op pt
    input wire logic [dtec_pkg::DTEC_DW-1:0] local_lim_high, // local high
    input wire logic [dtec_pkg::DTEC_DW-1:0] local_lim_low, // local low
    input wire logic [dtec_pkg::DTEC_DW-1:0] remote1_lim_high, // r1 high
    input wire logic [dtec_pkg::DTEC_DW-1:0] remote1_lim_low, // r1 low
    input wire logic [dtec_pkg::DTEC_DW-1:0] remote2_lim_high, // r2 high
    input wire logic [dtec_pkg::DTEC_DW-1:0] remote2_lim_low, // r2 low
    input wire logic adjust_tick, // monitoring cycle pulse
    output logic [dtec_pkg::DTEC_DW-1:0] cycle_config, // cycle fields
    output logic [dtec_pkg::DTEC_DW-1:0] remote2_op_point, // r2 op pt
    output logic [dtec_pkg::DTEC_DW-1:0] fan_start_temp_local, // local
    output logic [dtec_pkg::DTEC_DW-1:0] fan_start_temp_remote1, // r1
    output logic [dtec_pkg::DTEC_DW-1:0] fan_start_temp_remote2 // r2
);
    import dtec_pkg::*;

    dtec_bus_t bus_r;
    dtec_bus_t bus_nxt;
    logic waitrequest_r;
    logic [DTEC_BUS_DW-1:0] readdata_r;
    logic [DTEC_DW-1:0] enable_r;
    logic [DTEC_DW-1:0] enable_nxt;
    logic [DTEC_DW-1:0] cycle_r;
    logic [DTEC_DW-1:0] cycle_nxt;
    logic lock_r;
    logic [DTEC_DW-1:0] oppt_r;
    logic [DTEC_DW-1:0] oppt_nxt;
    logic [DTEC_DW-1:0] r2_latest_r;
    logic overtemp_prev_n_r;
    logic cycle_written_r;
    logic [DTEC_DW-1:0] rd_byte;

    // bus decode; a request is taken in the cycle waitrequest is low
    wire [7:0] idx_w = address[DTEC_ADDR_W-1:DTEC_IDX_LSB];
    wire [DTEC_DW-1:0] wbyte_w = writedata[DTEC_DW-1:0];
    wire req_w = read | write;
    wire take_w = write && !waitrequest_r;
    wire hit_enable_w = (idx_w == DTEC_IDX_ENABLE);
    wire hit_cycle_w = (idx_w == DTEC_IDX_CYCLE);
    wire hit_oppt_w = (idx_w == DTEC_IDX_OPPT_R2);
    wire hit_fst_l_w = (idx_w == DTEC_IDX_FST_LOCAL);
    wire hit_fst_r1_w = (idx_w == DTEC_IDX_FST_R1);
    wire hit_fst_r2_w = (idx_w == DTEC_IDX_FST_R2);
    wire hit_lock_w = (idx_w == DTEC_IDX_LOCK);
    wire hit_temp_w = (idx_w == DTEC_IDX_R2_TEMP);

    // the lock gates the control registers and itself
    wire wr_enable_w = take_w && hit_enable_w && !lock_r; // RQ8
    wire wr_cycle_w = take_w && hit_cycle_w && !lock_r; // RQ8
    wire wr_lock_w = take_w && hit_lock_w && !lock_r; // RQ8
    wire wr_oppt_w = take_w && hit_oppt_w;
    wire wr_fst_l_w = take_w && hit_fst_l_w;
    wire wr_fst_r1_w = take_w && hit_fst_r1_w;
    wire wr_fst_r2_w = take_w && hit_fst_r2_w;

    // capture fires once per falling edge of the pin
    wire capture_en_w = enable_r[DTEC_BIT_R2_CAPTURE];
    wire new_assert_w = overtemp_prev_n_r & ~overtemp_pin_n; // RQ10
    wire capture_w = capture_en_w && new_assert_w; // RQ1 RQ2

    // hardware capture wins over a software write in the same cycle
    assign oppt_nxt = capture_w ? r2_latest_r : // RQ1
        wr_oppt_w ? wbyte_w : oppt_r; // RQ2
    assign enable_nxt = wr_enable_w ? wbyte_w : enable_r;
    assign cycle_nxt = wr_cycle_w ? wbyte_w : cycle_r;

    // read mux; unmapped indices read zero
    assign rd_byte = hit_enable_w ? enable_r :
        hit_cycle_w ? cycle_r :
        hit_oppt_w ? oppt_r :
        hit_fst_l_w ? fan_start_temp_local :
        hit_fst_r1_w ? fan_start_temp_remote1 :
        hit_fst_r2_w ? fan_start_temp_remote2 :
        hit_lock_w ? {{(DTEC_DW-1){1'b0}}, lock_r} :
        hit_temp_w ? r2_latest_r : DTEC_RST_ENABLE;

    // one wait cycle, then one answer cycle, then back to stalling
    always_comb begin
        bus_nxt = bus_r;
        case (bus_r)
            DTEC_BUS_IDLE: begin
                if (req_w) begin
                    bus_nxt = DTEC_BUS_ACK;
                end
            end
            DTEC_BUS_ACK: begin
                bus_nxt = DTEC_BUS_IDLE;
            end
            default: begin
                bus_nxt = DTEC_BUS_IDLE;
            end
        endcase
    end

    // bus handshake flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_r <= DTEC_BUS_IDLE;
            waitrequest_r <= 1'b1;
            readdata_r <= '0;
        end else begin
            bus_r <= bus_nxt;
            waitrequest_r <= (bus_nxt != DTEC_BUS_ACK);
            readdata_r <= {{DTEC_PAD_W{1'b0}}, rd_byte};
        end
    end

    // control and status registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enable_r <= DTEC_RST_ENABLE;
            cycle_r <= DTEC_RST_CYCLE; // RQ9
            lock_r <= 1'b0;
            oppt_r <= DTEC_RST_OPPT;
            cycle_written_r <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            cycle_r <= cycle_nxt;
            lock_r <= lock_r | (wr_lock_w & wbyte_w[DTEC_BIT_LOCK]); // RQ8
            oppt_r <= oppt_nxt;
            cycle_written_r <= cycle_written_r | wr_cycle_w;
        end
    end

    // latest completed remote 2 reading and pin history
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r2_latest_r <= DTEC_RST_TEMP;
            overtemp_prev_n_r <= 1'b1;
        end else begin
            if (remote2_temp_valid) begin
                r2_latest_r <= remote2_temp; // RQ10
            end
            overtemp_prev_n_r <= overtemp_pin_n;
        end
    end

    // per-zone fan-start stepping, enable bit picks the zone
    dtec_zone u_zone_local (
        .clk(clk),
        .reset(reset),
        .dyn_en(enable_r[DTEC_BIT_LOCAL_DYN]), // RQ4
        .tick(adjust_tick),
        .temp(local_temp),
        .op_point(local_op_point),
        .lim_high(local_lim_high),
        .lim_low(local_lim_low),
        .sw_wr(wr_fst_l_w),
        .sw_data(wbyte_w),
        .fan_start(fan_start_temp_local)
    );
    dtec_zone u_zone_remote1 (
        .clk(clk),
        .reset(reset),
        .dyn_en(enable_r[DTEC_BIT_R1_DYN]), // RQ3
        .tick(adjust_tick),
        .temp(remote1_temp),
        .op_point(remote1_op_point),
        .lim_high(remote1_lim_high),
        .lim_low(remote1_lim_low),
        .sw_wr(wr_fst_r1_w),
        .sw_data(wbyte_w),
        .fan_start(fan_start_temp_remote1)
    );
    dtec_zone u_zone_remote2 (
        .clk(clk),
        .reset(reset),
        .dyn_en(enable_r[DTEC_BIT_R2_DYN]), // RQ5
        .tick(adjust_tick),
        .temp(remote2_temp),
        .op_point(oppt_r),
        .lim_high(remote2_lim_high),
        .lim_low(remote2_lim_low),
        .sw_wr(wr_fst_r2_w),
        .sw_data(wbyte_w),
        .fan_start(fan_start_temp_remote2)
    );

    // outputs straight from flops
    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    assign cycle_config = cycle_r;
    assign remote2_op_point = oppt_r;

    // checks
    capture_load_a: assert property (@(posedge clk) disable iff (reset) // RQ1
        capture_w |=> oppt_r == $past(r2_latest_r))
        else $error("operating point not loaded on capture");
    capture_off_a: assert property (@(posedge clk) disable iff (reset) // RQ2
        (!capture_en_w && !wr_oppt_w) |=> $stable(oppt_r))
        else $error("operating point moved with capture disabled");
    remote1_gate_a: assert property (@(posedge clk) disable iff (reset) // RQ3
        (!$past(wr_fst_r1_w) && !$stable(fan_start_temp_remote1))
        |-> $past(enable_r[DTEC_BIT_R1_DYN] && adjust_tick))
        else $error("remote 1 fan-start moved while disabled");
    local_gate_a: assert property (@(posedge clk) disable iff (reset) // RQ4
        (enable_r[DTEC_BIT_LOCAL_DYN] && adjust_tick && !wr_fst_l_w
        && local_temp > local_op_point
        && fan_start_temp_local > local_lim_low)
        |=> fan_start_temp_local != $past(fan_start_temp_local))
        else $error("local fan-start not adjusted when enabled");
    remote2_gate_a: assert property (@(posedge clk) disable iff (reset) // RQ5
        (!enable_r[DTEC_BIT_R2_DYN] && !wr_fst_r2_w)
        |=> $stable(fan_start_temp_remote2))
        else $error("remote 2 fan-start moved while disabled");
    lock_hold_a: assert property (@(posedge clk) disable iff (reset) // RQ8
        (lock_r && take_w && (hit_cycle_w || hit_enable_w))
        |=> $stable(cycle_r) && $stable(enable_r) && lock_r)
        else $error("locked control register was written");
    cycle_reset_a: assert property (@(posedge clk) disable iff (reset) // RQ9
        !cycle_written_r |-> cycle_r == DTEC_RST_CYCLE)
        else $error("cycle register left its reset value");
    capture_once_a: assert property (@(posedge clk) disable iff (reset) // RQ10
        capture_w |=> !capture_w)
        else $error("capture fired twice for one assertion");
    bus_answer_a: assert property (@(posedge clk) disable iff (reset)
        (req_w && waitrequest_r) |=> !waitrequest_r ##1 waitrequest_r)
        else $error("bus answer not one cycle after request");

    capture_seen_c: cover property (@(posedge clk) disable iff (reset)
        capture_w ##1 (read && hit_oppt_w));
    locked_write_c: cover property (@(posedge clk) disable iff (reset)
        lock_r && take_w && hit_cycle_w);
    zone_step_c: cover property (@(posedge clk) disable iff (reset)
        adjust_tick && enable_r[DTEC_BIT_R2_DYN]
        ##1 !$stable(fan_start_temp_remote2));
endmodule : dtec_regs

// file: dtec_testbench.sv
// self-checking bench for the dynamic fan-start control register bank
`timescale 1ns/10ps

module testbench;
    import dtec_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [DTEC_ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DTEC_BUS_DW-1:0] writedata = '0;
    logic [DTEC_BUS_DW-1:0] readdata;
    logic waitrequest;
    logic overtemp_pin_n = 1'b1;
    logic r2_valid = 1'b0;
    logic [7:0] r2_temp = 8'h00;
    logic [7:0] loc_temp = 8'h00;
    logic [7:0] r1_temp = 8'h00;
    logic [7:0] op_pt = 8'h28;
    logic [7:0] lim_hi = 8'h50;
    logic [7:0] lim_lo = 8'h10;
    logic tick = 1'b0;
    logic [7:0] cycle_config;
    logic [7:0] r2_oppt;
    logic [7:0] fs_l;
    logic [7:0] fs_r1;
    logic [7:0] fs_r2;
    logic [7:0] fs [3];
    logic [7:0] exp_fs [3];
    logic [31:0] rd;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int z;

    dtec_regs u_dtec_regs (.clk(clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .overtemp_pin_n(overtemp_pin_n), .remote2_temp_valid(r2_valid),
        .remote2_temp(r2_temp), .local_temp(loc_temp),
        .remote1_temp(r1_temp), .local_op_point(op_pt),
        .remote1_op_point(op_pt), .local_lim_high(lim_hi),
        .local_lim_low(lim_lo), .remote1_lim_high(lim_hi),
        .remote1_lim_low(lim_lo), .remote2_lim_high(lim_hi),
        .remote2_lim_low(lim_lo), .adjust_tick(tick),
        .cycle_config(cycle_config), .remote2_op_point(r2_oppt),
        .fan_start_temp_local(fs_l), .fan_start_temp_remote1(fs_r1),
        .fan_start_temp_remote2(fs_r2));

    // array copy kept procedural so each port drives a plain variable
    always_comb begin
        fs[0] = fs_l;
        fs[1] = fs_r1;
        fs[2] = fs_r2;
    end

    // 40 mhz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // hang guard; the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= {idx, 2'b00};
        writedata <= {24'h000000, d};
        write <= wr;
        read <= ~wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] dummy;
        bus(1'b1, idx, d, dummy);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00, rd);
        chk(rd, {24'h000000, e});
    endtask : rd_chk

    // one-cycle pulse on tick or valid, then let the result land
    task automatic pulse(input logic is_tick);
        @(posedge clk);
        if (is_tick) tick <= 1'b1;
        else r2_valid <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        r2_valid <= 1'b0;
        @(posedge clk);
    endtask : pulse

    task automatic pin(input logic lvl);
        @(posedge clk);
        overtemp_pin_n <= lvl;
        repeat (2) @(posedge clk);
    endtask : pin

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        // reset values and plain read/write of the cycle register
        rd_chk(DTEC_IDX_CYCLE, 8'h00);
        chk(cycle_config, 8'h00);
        rd_chk(DTEC_IDX_ENABLE, 8'h00);
        wr_reg(DTEC_IDX_CYCLE, 8'ha5);
        rd_chk(DTEC_IDX_CYCLE, 8'ha5);
        chk(cycle_config, 8'ha5);
        rd_chk(8'h10, 8'h00);
        // capture disabled: pin assertion leaves the programmed value
        wr_reg(DTEC_IDX_OPPT_R2, 8'h20);
        r2_temp <= 8'h55;
        pulse(1'b0);
        pin(1'b0);
        chk(r2_oppt, 8'h20);
        pin(1'b1);
        rd_chk(DTEC_IDX_OPPT_R2, 8'h20);
        // capture enabled: one copy per falling edge of the pin
        wr_reg(DTEC_IDX_ENABLE, 8'h10);
        pin(1'b0);
        chk(r2_oppt, 8'h55);
        r2_temp <= 8'h66;
        pulse(1'b0);
        chk(r2_oppt, 8'h55);
        pin(1'b1);
        pin(1'b0);
        chk(r2_oppt, 8'h66);
        rd_chk(DTEC_IDX_R2_TEMP, 8'h66);
        pin(1'b1);
        // zone steps: only the enabled zone moves on a tick
        wr_reg(DTEC_IDX_ENABLE, 8'h00);
        wr_reg(DTEC_IDX_OPPT_R2, 8'h28);
        loc_temp <= 8'h40;
        r1_temp <= 8'h40;
        r2_temp <= 8'h40;
        for (z = 0; z < 3; z++) begin
            wr_reg(DTEC_IDX_FST_LOCAL + 8'(z), 8'h30);
            exp_fs[z] = 8'h30;
        end
        pulse(1'b1);
        for (z = 0; z < 3; z++) chk(fs[z], exp_fs[z]);
        for (z = 0; z < 3; z++) begin
            wr_reg(DTEC_IDX_ENABLE, 8'h01 << (z == 0 ? DTEC_BIT_LOCAL_DYN :
                   z == 1 ? DTEC_BIT_R1_DYN : DTEC_BIT_R2_DYN));
            pulse(1'b1);
            exp_fs[z] = exp_fs[z] - 8'h01;
            chk(fs[0], exp_fs[0]);
            chk(fs[1], exp_fs[1]);
            chk(fs[2], exp_fs[2]);
        end
        rd_chk(DTEC_IDX_FST_R2, exp_fs[2]);
        // cold local zone raises its fan-start temperature
        wr_reg(DTEC_IDX_ENABLE, 8'h40);
        loc_temp <= 8'h05;
        pulse(1'b1);
        chk(fs[0], exp_fs[0] + 8'h01);
        wr_reg(DTEC_IDX_ENABLE, 8'h00);
        pulse(1'b1);
        chk(fs[0], exp_fs[0] + 8'h01);
        // lock: later writes to the control registers are dropped
        wr_reg(DTEC_IDX_ENABLE, 8'h80);
        wr_reg(DTEC_IDX_LOCK, 8'h01);
        wr_reg(DTEC_IDX_ENABLE, 8'h3f);
        rd_chk(DTEC_IDX_ENABLE, 8'h80);
        wr_reg(DTEC_IDX_CYCLE, 8'h11);
        rd_chk(DTEC_IDX_CYCLE, 8'ha5);
        chk(cycle_config, 8'ha5);
        wr_reg(DTEC_IDX_LOCK, 8'h00);
        rd_chk(DTEC_IDX_LOCK, 8'h01);
        finish_test();
    end
endmodule : testbench
